//--- rtl/ida_indirect_addr.sv
// Banked data space with access window and three auto-stepping pointers
//
// The APB register port and the register addresses were decided locally.
`default_nettype none
// Operation
// - Every data location is addressed with 12 bits, 4,096 bytes in all.
// - Data space is 16 banks of 256 bytes; banks 0-14 are RAM, bank 15 holds the SFRs.
// - Reading an unimplemented location returns zero.
// - A 256-byte access window reaches SFRs and low bank 0 without bank select.
// - Three pointer pairs, high nibble of high byte unused, give 12-bit addresses.
// - Indirect operands are virtual SPECIAL_FUNCTION_REGS slots with no storage of their own.
// - Plain indirect operand accesses the pointed location, pointer unchanged.
// - Indirect addresses use the full pointer, ignoring bank select and window bit.
// - Use-then-drop uses the pointer, then decrements the pair by 1.
// - Use-then-bump uses the pointer, then increments the pair by 1.
// - Bump-then-use increments the pair by 1, then uses the new value.
// - Plus-accumulator adds signed accumulator to pointer; neither value changes.
// - Steps act on the whole pair, low byte carrying into the high byte.
// - Automatic pointer steps never touch any status flag.
module ida_indirect_addr (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire ida_pkg::ida_apb_req_s apbReq,
  output var  ida_pkg::ida_apb_rsp_s apbRsp
);
  ida_pkg::ida_state_s st_reg;
  ida_pkg::ida_state_s st_next;

  logic        badAddr;
  logic [11:0] dataAddr;
  logic [5:0]  slot;
  logic [5:0]  tgtSlot;
  logic        hit;
  logic [1:0]  ptrIdx;
  logic [2:0]  kind;
  logic [11:0] ptrVal;
  logic [11:0] target;
  logic        isVirt;
  logic        tgtVirt;
  logic [7:0]  rdByte;
  logic        setupDone;
  logic        finish;

  // ************************************************
  // Decode helpers
  // ************************************************
  // Returns {hit, pointer index, operand kind} for an SPECIAL_FUNCTION_REGS-bank address
  function automatic logic [5:0] slotOf(input logic [11:0] a);
    logic [7:0] rel;
    logic       h;
    rel = a[7:0] - ida_pkg::PTR_BASE;
    h = (a >= ida_pkg::SFR_BASE) && (a[7:0] >= ida_pkg::PTR_BASE)
        && (rel[7:3] < ida_pkg::PTR_SLOTS) && (rel[2:0] <= ida_pkg::REG_LOW);
    return {h, rel[4:3], rel[2:0]};
  endfunction

  function automatic logic [7:0] rdPhys(input ida_pkg::ida_state_s s,
                                        input logic [11:0]         a);
    logic [5:0] sl;
    logic [7:0] d;
    sl = slotOf(a);
    d = 8'h00;
    if (a < ida_pkg::SFR_BASE)
      d = s.ram[a];
    else if (sl[5] && sl[2:0] == ida_pkg::REG_HIGH)
      d = {4'h0, s.ptr[sl[4:3]][11:8]};
    else if (sl[5] && sl[2:0] == ida_pkg::REG_LOW)
      d = s.ptr[sl[4:3]][7:0];
    else if (a[7:0] == ida_pkg::ACC_OFS)
      d = s.acc;
    else if (a[7:0] == ida_pkg::BSR_OFS)
      d = {4'h0, s.bank_select_register};
    return d;
  endfunction

  function automatic ida_pkg::ida_state_s wrPhys(
    input ida_pkg::ida_state_s s,
    input logic [11:0]         a,
    input logic [7:0]          d);
    logic [5:0]          sl;
    ida_pkg::ida_state_s r;
    sl = slotOf(a);
    r = s;
    if (a < ida_pkg::SFR_BASE)
      r.ram[a] = d;
    else if (sl[5] && sl[2:0] == ida_pkg::REG_HIGH)
      r.ptr[sl[4:3]][11:8] = d[3:0];
    else if (sl[5] && sl[2:0] == ida_pkg::REG_LOW)
      r.ptr[sl[4:3]][7:0] = d;
    else if (a[7:0] == ida_pkg::ACC_OFS)
      r.acc = d;
    else if (a[7:0] == ida_pkg::BSR_OFS)
      r.bank_select_register = d[3:0];
    return r;
  endfunction

  // ************************************************
  // Address formation
  // ************************************************
  always_comb
  begin
    badAddr = apbReq.paddr[ida_pkg::ERR_BIT] | (|apbReq.paddr[1:0]);
    if (!apbReq.paddr[ida_pkg::BANKED_BIT])
      dataAddr = apbReq.paddr[13:2];
    else if (apbReq.paddr[ida_pkg::ACCESS_BIT])
    begin
      if (apbReq.paddr[9:2] < ida_pkg::ACCESS_SPLIT)
        dataAddr = {4'h0, apbReq.paddr[9:2]};
      else
        dataAddr = {4'hf, apbReq.paddr[9:2]};
    end
    else
      dataAddr = {st_reg.bank_select_register, apbReq.paddr[9:2]};
    slot   = slotOf(dataAddr);
    hit    = slot[5];
    ptrIdx = slot[4:3];
    kind   = slot[2:0];
    ptrVal = hit ? st_reg.ptr[ptrIdx] : ida_pkg::PTR_RESET;
    isVirt = hit && (kind <= ida_pkg::OP_PLUS_ACC);
    // Pointer, plus one for bump-then-use or the accumulator for plus-accumulator, decides the target; bank select plays no part
    case (kind)
      ida_pkg::OP_BUMP_USE: target = ptrVal + 12'h001;
      ida_pkg::OP_PLUS_ACC:
        target = ptrVal + {{4{st_reg.acc[7]}}, st_reg.acc};
      default: target = ptrVal;
    endcase
    if (!isVirt)
      target = dataAddr;
    tgtSlot = slotOf(target);
    // Indirect access of an indirect operand is a null access
    tgtVirt = isVirt && tgtSlot[5] && (tgtSlot[2:0] <= ida_pkg::OP_PLUS_ACC);
    rdByte  = tgtVirt ? 8'h00 : rdPhys(st_reg, target);
  end

  // ************************************************
  // APB slave and pointer update
  // ************************************************
  assign setupDone = apbReq.psel && apbReq.penable && !st_reg.rsp.pready;
  assign finish    = apbReq.psel && apbReq.penable && st_reg.rsp.pready;

  always_comb
  begin
    st_next = st_reg;
    st_next.rsp.pready  = 1'b0;
    st_next.rsp.pslverr = 1'b0;
    st_next.rsp.prdata  = 32'h0000_0000;
    if (setupDone)
    begin
      // Read data is captured one cycle early so the outputs stay registered
      st_next.rsp.pready  = 1'b1;
      st_next.rsp.pslverr = badAddr;
      if (!badAddr && !apbReq.pwrite)
        st_next.rsp.prdata = {24'h00_0000, rdByte};
    end
    else if (finish && !badAddr)
    begin
      // Only the pointer moves; no status flag lives here to disturb
      if (isVirt && kind == ida_pkg::OP_DROP)
        st_next.ptr[ptrIdx] = ptrVal - 12'h001;
      else if (isVirt && (kind == ida_pkg::OP_BUMP
                          || kind == ida_pkg::OP_BUMP_USE))
        st_next.ptr[ptrIdx] = ptrVal + 12'h001;
      if (apbReq.pwrite && apbReq.pstrb[0] && !tgtVirt)
        st_next = wrPhys(st_next, target, apbReq.pwdata[7:0]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_reg       <= '0;
      st_reg.ptr   <= {3{ida_pkg::PTR_RESET}};
      st_reg.acc   <= ida_pkg::ACC_RESET;
      st_reg.bank_select_register   <= ida_pkg::BSR_RESET;
    end
    else
      st_reg <= st_next;
  end

  assign apbRsp = st_reg.rsp;

  // ************************************************
  // Assertions
  // ************************************************
  a_ready_wait: assert property (@(posedge clk) disable iff (srst)
    setupDone |=> apbRsp.pready)
    else $error("pready missing one cycle after access start");

  a_ready_single: assert property (@(posedge clk) disable iff (srst)
    apbRsp.pready |=> !apbRsp.pready)
    else $error("pready held longer than one cycle");

  a_drop_step: assert property (@(posedge clk) disable iff (srst)
    finish && !badAddr && isVirt && kind == ida_pkg::OP_DROP
      && !apbReq.pwrite
    |=> st_reg.ptr[$past(ptrIdx)] == $past(ptrVal) - 12'h001)
    else $error("use-then-drop did not decrement pointer");

  a_bump_step: assert property (@(posedge clk) disable iff (srst)
    finish && !badAddr && isVirt && kind == ida_pkg::OP_BUMP
      && !apbReq.pwrite
    |=> st_reg.ptr[$past(ptrIdx)] == $past(ptrVal) + 12'h001)
    else $error("use-then-bump did not increment pointer");

  a_plain_keep: assert property (@(posedge clk) disable iff (srst)
    finish && isVirt && !apbReq.pwrite
      && (kind == ida_pkg::OP_PLAIN || kind == ida_pkg::OP_PLUS_ACC)
    |=> st_reg.ptr[$past(ptrIdx)] == $past(ptrVal)
        && st_reg.acc == $past(st_reg.acc))
    else $error("plain or offset operand changed pointer");

  a_indirect_read: assert property (@(posedge clk) disable iff (srst)
    setupDone && isVirt && !apbReq.pwrite && !badAddr
      && target < ida_pkg::SFR_BASE
    |=> apbRsp.prdata[7:0] == st_reg.ram[$past(target)])
    else $error("indirect read returned wrong byte");

  a_pointer_bump_then_use_addr: assert property (@(posedge clk) disable iff (srst)
    isVirt && kind == ida_pkg::OP_BUMP_USE
    |-> target == ptrVal + 12'h001)
    else $error("bump-then-use target is not pointer plus one");

  a_null_zero: assert property (@(posedge clk) disable iff (srst)
    setupDone && (tgtVirt || badAddr)
    |=> apbRsp.prdata == 32'h0000_0000)
    else $error("null or bad access returned nonzero data");

  a_bad_error: assert property (@(posedge clk) disable iff (srst)
    setupDone && badAddr |=> apbRsp.pslverr ##1 !apbRsp.pslverr)
    else $error("bad address not flagged for exactly one cycle");

  // ************************************************
  // Decode and refusal checks
  // ************************************************
  a_rsp_idle: assert property (@(posedge clk) disable iff (srst)
    !apbRsp.pready |-> apbRsp.prdata == 32'h0000_0000 && !apbRsp.pslverr)
    else $error("response fields nonzero while pready is low");

  a_rdata_upper: assert property (@(posedge clk) disable iff (srst)
    apbRsp.prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  a_hi_read: assert property (@(posedge clk) disable iff (srst)
    setupDone && hit && kind == ida_pkg::REG_HIGH && !apbReq.pwrite
      && !badAddr |=> apbRsp.prdata[7:4] == 4'h0)
    else $error("pointer high byte read shows unused bits");

  a_bad_nostep: assert property (@(posedge clk) disable iff (srst)
    finish && badAddr |=> st_reg.ptr == $past(st_reg.ptr))
    else $error("refused access moved a pointer");

  a_bad_nowrite: assert property (@(posedge clk) disable iff (srst)
    finish && badAddr
    |=> st_reg.acc == $past(st_reg.acc) && st_reg.bank_select_register == $past(st_reg.bank_select_register))
    else $error("refused access changed a register");

  a_idle_hold: assert property (@(posedge clk) disable iff (srst)
    !finish |=> st_reg.ptr == $past(st_reg.ptr))
    else $error("pointer changed outside a completed access");

  a_bump_use_step: assert property (@(posedge clk) disable iff (srst)
    finish && !badAddr && isVirt && kind == ida_pkg::OP_BUMP_USE
      && !apbReq.pwrite
    |=> st_reg.ptr[$past(ptrIdx)] == $past(ptrVal) + 12'h001)
    else $error("bump-then-use did not increment pointer");

  a_unimpl_zero: assert property (@(posedge clk) disable iff (srst)
    setupDone && !badAddr && !hit && dataAddr >= ida_pkg::SFR_BASE
      && dataAddr[7:0] != ida_pkg::ACC_OFS
      && dataAddr[7:0] != ida_pkg::BSR_OFS |=> apbRsp.prdata == 32'h0000_0000)
    else $error("unimplemented location read nonzero");

  a_window_low: assert property (@(posedge clk) disable iff (srst)
    apbReq.paddr[ida_pkg::BANKED_BIT] && apbReq.paddr[ida_pkg::ACCESS_BIT]
      && apbReq.paddr[9:2] < ida_pkg::ACCESS_SPLIT |-> dataAddr[11:8] == 4'h0)
    else $error("low access window not mapped to bank 0");

  a_window_high: assert property (@(posedge clk) disable iff (srst)
    apbReq.paddr[ida_pkg::BANKED_BIT] && apbReq.paddr[ida_pkg::ACCESS_BIT]
      && apbReq.paddr[9:2] >= ida_pkg::ACCESS_SPLIT |-> dataAddr[11:8] == 4'hf)
    else $error("high access window not mapped to SPECIAL_FUNCTION_REGS bank");

  a_linear_addr: assert property (@(posedge clk) disable iff (srst)
    !apbReq.paddr[ida_pkg::BANKED_BIT] |-> dataAddr == apbReq.paddr[13:2])
    else $error("linear address not taken whole");

  a_banked_addr: assert property (@(posedge clk) disable iff (srst)
    apbReq.paddr[ida_pkg::BANKED_BIT] && !apbReq.paddr[ida_pkg::ACCESS_BIT]
    |-> dataAddr[11:8] == st_reg.bank_select_register)
    else $error("banked address ignores bank select");

  a_direct_target: assert property (@(posedge clk) disable iff (srst)
    !isVirt |-> target == dataAddr)
    else $error("direct access target differs from decoded address");

  a_ready_cause: assert property (@(posedge clk) disable iff (srst)
    apbRsp.pready |-> $past(setupDone))
    else $error("pready without a preceding access phase");
endmodule
`default_nettype wire

//--- rtl/ida_pkg.sv
// Constants, carrier structs and state layout of the indirect addressing unit
`default_nettype none
package ida_pkg;
  // ************************************************
  // Data space
  // ************************************************
  localparam int          ADDR_W       = 12;
  localparam int          DATA_SPACE   = 4096;
  localparam int          BANK_COUNT   = 16;
  localparam int          BANK_BYTES   = 256;
  localparam logic [11:0] SFR_BASE     = 12'hf00;
  localparam int          GPR_BYTES    = 3840;
  // Access window: low half from bank 0, high half from the SPECIAL_FUNCTION_REGS bank
  localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
  // ************************************************
  // SPECIAL_FUNCTION_REGS slots (low byte of addresses in the SPECIAL_FUNCTION_REGS bank)
  // ************************************************
  localparam logic [7:0]  PTR_BASE     = 8'he0;
  localparam logic [4:0]  PTR_SLOTS    = 5'h03;
  localparam logic [2:0]  OP_PLAIN     = 3'h0;
  localparam logic [2:0]  OP_DROP      = 3'h1;
  localparam logic [2:0]  OP_BUMP      = 3'h2;
  localparam logic [2:0]  OP_BUMP_USE  = 3'h3;
  localparam logic [2:0]  OP_PLUS_ACC  = 3'h4;
  localparam logic [2:0]  REG_HIGH     = 3'h5;
  localparam logic [2:0]  REG_LOW      = 3'h6;
  localparam logic [7:0]  ACC_OFS      = 8'hf8;
  localparam logic [7:0]  BSR_OFS      = 8'hf9;
  // ************************************************
  // APB address layout and reset values
  // ************************************************
  localparam int          BANKED_BIT   = 14;
  localparam int          ACCESS_BIT   = 10;
  localparam int          ERR_BIT      = 15;
  localparam logic [11:0] PTR_RESET    = 12'h000;
  localparam logic [7:0]  ACC_RESET    = 8'h00;
  localparam logic [3:0]  BSR_RESET    = 4'h0;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } ida_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ida_apb_rsp_s;

  typedef struct packed {
    logic [GPR_BYTES-1:0][7:0] ram;
    logic [2:0][11:0]          ptr;
    logic [7:0]                acc;
    logic [3:0]                bank_select_register;
    ida_apb_rsp_s              rsp;
  } ida_state_s;
endpackage
`default_nettype wire

//--- testbench/ida_core_model.sv
// Core-side master model issuing data accesses over APB
`default_nettype none
module ida_core_model (
  input  wire logic                  clk,
  output var  ida_pkg::ida_apb_req_s apbReq,
  input  wire ida_pkg::ida_apb_rsp_s apbRsp
);
  timeunit 1ns;
  timeprecision 1ns;
  int nTimeouts = 0;
  initial apbReq = '0;
  // ****
  // Transfer
  // ****
  // Request held until pready is seen at an edge; no latency is assumed
  task automatic xfer(
    input  logic        wr,
    input  logic [15:0] pa,
    input  logic [7:0]  wd,
    output logic [7:0]  rd,
    output logic        er
  );
    int i;
    apbReq <= '{1'b1, 1'b0, wr, pa, {24'h0, wd}, 4'hf};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      if (apbRsp.pready === 1'b1)
        break;
    end
    if (i == 16)
      nTimeouts++;
    rd = apbRsp.prdata[7:0];
    er = apbRsp.pslverr;
    apbReq <= '0;
    // Idle edge so the next setup never lands in the same time step
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- testbench/ida_indirect_addr_bench.sv
// Self-checking bench for the indirect addressing unit
`default_nettype none
module ida_indirect_addr_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk = 1'b0;
  logic                  srst = 1'b1;
  ida_pkg::ida_apb_req_s apbReq;
  ida_pkg::ida_apb_rsp_s apbRsp;
  int                    n_fail = 0;
  int                    tests_run = 0;
  always #25 clk = ~clk;
  ida_indirect_addr i_ida_indirect_addr (
    .clk    (clk),
    .srst   (srst),
    .apbReq (apbReq),
    .apbRsp (apbRsp)
  );
  ida_core_model i_ida_core_model (
    .clk    (clk),
    .apbReq (apbReq),
    .apbRsp (apbRsp)
  );
  // ****
  // Helpers
  // ****
  function automatic logic [15:0] lin(input logic [11:0] a);
    return {2'b00, a, 2'b00};
  endfunction
  function automatic logic [15:0] bnk(input logic w, input logic [7:0] f);
    return {2'b01, 3'h0, w, f, 2'b00};
  endfunction
  task automatic cmp(input string n, input logic [7:0] x,
                     input logic [7:0] g);
    tests_run++;
    if (g !== x)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic end_of_test();
    n_fail += i_ida_core_model.nTimeouts;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic go(input logic [15:0] pa, input logic w, input logic [7:0] d,
                    input logic [7:0] x);
    logic [7:0] q;
    logic       e;
    i_ida_core_model.xfer(w, pa, d, q, e);
    if (i_ida_core_model.nTimeouts != 0)
    begin
      n_fail++;
      end_of_test();
    end
    if (!w)
      cmp("read data", x, q);
    cmp("error flag", 8'h00, {7'h0, e});
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    go(lin(a), 1'b1, d, 8'h00);
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] x);
    go(lin(a), 1'b0, 8'h00, x);
  endtask
  // Pointer n sits at 0xfe0 + 8n; high byte at +5, low byte at +6
  task automatic ps(input int n, input logic [11:0] v);
    wr(12'hfe5 + 12'(8 * n), {4'h0, v[11:8]});
    wr(12'hfe6 + 12'(8 * n), v[7:0]);
  endtask
  task automatic pc(input int n, input logic [11:0] v);
    rc(12'hfe5 + 12'(8 * n), {4'h0, v[11:8]});
    rc(12'hfe6 + 12'(8 * n), v[7:0]);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_space();
    wr(12'h000, 8'ha5);
    wr(12'hc37, 8'h5a);
    wr(12'heff, 8'h3c);
    rc(12'h000, 8'ha5);
    rc(12'hc37, 8'h5a);
    rc(12'heff, 8'h3c);
    rc(12'hf00, 8'h00);
    rc(12'hfe7, 8'h00);
    $display("space test done");
  endtask
  task automatic t_window();
    go(bnk(1'b1, 8'h10), 1'b1, 8'h66, 8'h00);
    rc(12'h010, 8'h66);
    wr(12'hff9, 8'h03);
    go(bnk(1'b0, 8'h20), 1'b1, 8'h44, 8'h00);
    rc(12'h320, 8'h44);
    wr(12'hff8, 8'h9e);
    go(bnk(1'b1, 8'hf8), 1'b0, 8'h00, 8'h9e);
    $display("window test done");
  endtask
  task automatic t_plain();
    ps(0, 12'h320);
    go(bnk(1'b1, 8'he0), 1'b0, 8'h00, 8'h44);
    wr(12'hfe0, 8'h55);
    rc(12'h320, 8'h55);
    pc(0, 12'h320);
    wr(12'hfe5, 8'hff);
    rc(12'hfe5, 8'h0f);
    ps(0, 12'hfe0);
    rc(12'hfe0, 8'h00);
    $display("plain test done");
  endtask
  task automatic t_steps();
    ps(1, 12'h0ff);
    wr(12'hfea, 8'h11);
    pc(1, 12'h100);
    wr(12'hfeb, 8'h22);
    pc(1, 12'h101);
    rc(12'hfe9, 8'h22);
    rc(12'hfe9, 8'h00);
    pc(1, 12'h0ff);
    rc(12'h0ff, 8'h11);
    ps(2, 12'hfff);
    rc(12'hff2, 8'h00);
    pc(2, 12'h000);
    rc(12'hff1, 8'ha5);
    pc(2, 12'hfff);
    $display("step test done");
  endtask
  task automatic t_offset();
    ps(0, 12'h101);
    wr(12'hff8, 8'hfe);
    rc(12'hfe4, 8'h11);
    wr(12'hff8, 8'h05);
    wr(12'hfe4, 8'h33);
    rc(12'h106, 8'h33);
    pc(0, 12'h101);
    rc(12'hff8, 8'h05);
    $display("offset test done");
  endtask
  // Refused addresses flag an error and leave storage alone
  task automatic t_refuse();
    logic [7:0] q;
    logic       e;
    i_ida_core_model.xfer(1'b1, 16'h8000 | lin(12'h050), 8'h77, q, e);
    cmp("error flag", 8'h01, {7'h0, e});
    rc(12'h050, 8'h00);
    i_ida_core_model.xfer(1'b0, lin(12'h000) | 16'h0001, 8'h00, q, e);
    cmp("error flag", 8'h01, {7'h0, e});
    cmp("read data", 8'h00, q);
    $display("refuse test done");
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_space();
    t_window();
    t_plain();
    t_steps();
    t_offset();
    t_refuse();
    end_of_test();
  end
endmodule
`default_nettype wire
